// ---- hdl/ccst_defs.svh ----
// register offsets, field positions and reset values of the status/trigger block
`ifndef CCST_DEFS_SVH
`define CCST_DEFS_SVH

// ==================================================
// register byte offsets
`define CCST_OFF_STATUS   8'h00
`define CCST_OFF_CTRL     8'h04
`define CCST_OFF_CAPBUF   8'h08
`define CCST_OFF_IRQ_STAT 8'h0C
`define CCST_OFF_IRQ_MASK 8'h10

// ==================================================
// ccp_status_low fields
`define CCST_ST_TRIG  7
`define CCST_ST_TRIGGER_SET_REQUEST 6
`define CCST_ST_TRIGGER_CLEAR_REQUEST 5
`define CCST_ST_AUTO_SHUTDOWN_FLAG 4
`define CCST_ST_SINGLE_EDGE_COMPARE_FLAG 3
`define CCST_ST_CAPTURE_DISABLE_FLAG 2
`define CCST_ST_CAPTURE_OVERFLOW_FLAG  1
`define CCST_ST_CAPTURE_BUFFER_NOT_EMPTY 0

// ==================================================
// control register fields
`define CCST_CT_TRIGGER_ENABLE_SETTING  0
`define CCST_CT_GSM_LO  1
`define CCST_CT_PSSA_LO 3
`define CCST_CT_PSSB_LO 5

// ==================================================
// interrupt status and mask fields
`define CCST_IRQ_SHDN 0
`define CCST_IRQ_CMP  1
`define CCST_IRQ_OVF  2
`define CCST_IRQ_CAP  3

// ==================================================
// reset values
`define CCST_RST_CTRL 7'h00
`define CCST_RST_MASK 4'h0

`endif

// ---- hdl/ccst_pkg.sv ----
// types shared by the status/trigger block
package ccst_pkg;

	// ==================================================
	// bus responses
	typedef enum logic [1:0] {
		CCST_RESP_OKAY   = 2'b00,
		CCST_RESP_SLVERR = 2'b10
	} ccst_resp_t;

	// ==================================================
	// capture gating modes
	typedef enum logic [1:0] {
		CCST_GSM_LEVEL    = 2'b00,
		CCST_GSM_ONE_RISE = 2'b01,
		CCST_GSM_ONE_FALL = 2'b10,
		CCST_GSM_RESERVED = 2'b11
	} ccst_gsm_t;

	// ==================================================
	// shutdown states of an output group
	typedef enum logic [1:0] {
		CCST_PSS_TRI0     = 2'b00,
		CCST_PSS_TRI1     = 2'b01,
		CCST_PSS_INACTIVE = 2'b10,
		CCST_PSS_ACTIVE   = 2'b11
	} ccst_pss_t;

endpackage

// ---- hdl/ccst_sync2.sv ----
// two flip-flop synchroniser for pin inputs
module ccst_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} ccst_sync_t;

	ccst_sync_t st;
	ccst_sync_t next_st;

	always_comb begin
		next_st.meta   = d;
		next_st.stable = st.meta;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.stable;

endmodule

// ---- hdl/ccst_status.sv ----
// status, trigger request, capture buffer and shutdown logic with an AXI4-Lite slave
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`include "ccst_defs.svh"

module ccst_status #(
	parameter int ADDR_W = 8,
	parameter int CAP_W  = 16,
	parameter int DEPTH  = 4
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              capture_pin,
	input  wire logic              gate_pin,
	input  wire logic              shutdown_pin,
	input  wire logic              compare_match,
	input  wire logic [CAP_W-1:0]  time_base_value,
	input  wire logic              pwm_a,
	input  wire logic              pwm_b,
	output logic                   trigger_running_flag,
	output logic                   out_a,
	output logic                   out_a_oe_n,
	output logic                   out_b,
	output logic                   out_b_oe_n,
	output logic                   irq
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	// ==================================================
	// state
	typedef struct packed {
		logic                        awready;
		logic                        wready;
		logic                        bvalid;
		ccst_pkg::ccst_resp_t        bresp;
		logic                        arready;
		logic                        rvalid;
		ccst_pkg::ccst_resp_t        rresp;
		logic [31:0]                 rdata;
		logic                        aw_got;
		logic [ADDR_W-1:0]           awaddr;
		logic                        w_got;
		logic [31:0]                 wdata;
		logic [3:0]                  wstrb;
		logic                        trigger_enable_setting;
		ccst_pkg::ccst_gsm_t         capture_gating_mode;
		ccst_pkg::ccst_pss_t         shutdown_state_group_a;
		ccst_pkg::ccst_pss_t         shutdown_state_group_b;
		logic                        trigger_running_flag;
		logic                        auto_shutdown_flag;
		logic                        single_edge_compare_flag;
		logic                        capture_disable_flag;
		logic                        capture_overflow_flag;
		logic [DEPTH-1:0][CAP_W-1:0] fifo;
		logic [PTR_W-1:0]            rptr;
		logic [PTR_W-1:0]            wptr;
		logic [CNT_W-1:0]            cnt;
		logic                        cap_q;
		logic                        gate_q;
		logic [3:0]                  irq_stat;
		logic [3:0]                  irq_mask;
		logic                        irq;
		logic                        out_a;
		logic                        out_a_oe_n;
		logic                        out_b;
		logic                        out_b_oe_n;
	} ccst_state_t;

	ccst_state_t st;
	ccst_state_t next_st;

	logic [2:0]        pins_s;
	logic              cap_s;
	logic              gate_s;
	logic              sd_s;
	logic              aw_hs;
	logic              w_hs;
	logic              ar_hs;
	logic              wr_exec;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_stat;
	logic              cap_rise;
	logic              gate_rise;
	logic              gate_fall;
	logic              rd_pop;
	logic              push;

	// ==================================================
	// helpers
	function automatic logic ccst_mapped(input logic [ADDR_W-1:0] a);
		ccst_mapped = (a == ADDR_W'(`CCST_OFF_STATUS)) || (a == ADDR_W'(`CCST_OFF_CTRL)) ||
			(a == ADDR_W'(`CCST_OFF_CAPBUF)) || (a == ADDR_W'(`CCST_OFF_IRQ_STAT)) ||
			(a == ADDR_W'(`CCST_OFF_IRQ_MASK));
	endfunction

	// returns {level, oe_n}; oe_n low while the pin is driven
	function automatic logic [1:0] ccst_drive(input ccst_pkg::ccst_pss_t pss, input logic pwm, input logic sd);
		if (!sd) begin
			ccst_drive = {pwm, 1'b0};
		end else begin
			case (pss)
				ccst_pkg::CCST_PSS_ACTIVE:   ccst_drive = 2'b10;
				ccst_pkg::CCST_PSS_INACTIVE: ccst_drive = 2'b00;
				default:                     ccst_drive = 2'b01;
			endcase
		end
	endfunction

	// ==================================================
	// pin synchronisers
	ccst_sync2 #(
		.WIDTH(3)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({shutdown_pin, gate_pin, capture_pin}),
		.q       (pins_s)
	);

	assign cap_s  = pins_s[0];
	assign gate_s = pins_s[1];
	assign sd_s   = pins_s[2];

	// ==================================================
	// next state
	always_comb begin
		next_st   = st;
		aw_hs     = s_axi_awvalid && st.awready;
		w_hs      = s_axi_wvalid && st.wready;
		ar_hs     = s_axi_arvalid && st.arready;
		wr_addr   = st.aw_got ? st.awaddr : s_axi_awaddr;
		wr_data   = st.w_got ? st.wdata : s_axi_wdata;
		wr_strb   = st.w_got ? st.wstrb : s_axi_wstrb;
		wr_exec   = (st.aw_got || aw_hs) && (st.w_got || w_hs) && !st.bvalid;
		wr_stat   = wr_exec && wr_strb[0] && (wr_addr == ADDR_W'(`CCST_OFF_STATUS));
		cap_rise  = cap_s && !st.cap_q;
		gate_rise = gate_s && !st.gate_q;
		gate_fall = !gate_s && st.gate_q;
		rd_pop    = ar_hs && (s_axi_araddr == ADDR_W'(`CCST_OFF_CAPBUF)) && (st.cnt != '0);
		push      = 1'b0;
		next_st.cap_q  = cap_s;
		next_st.gate_q = gate_s;

		// write channel
		if (aw_hs) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (w_hs) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (wr_exec) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = ccst_mapped(wr_addr) ? ccst_pkg::CCST_RESP_OKAY : ccst_pkg::CCST_RESP_SLVERR;
		end
		next_st.awready = !next_st.aw_got && !next_st.bvalid;
		next_st.wready  = !next_st.w_got && !next_st.bvalid;

		// software writes; upper byte lanes carry nothing
		if (wr_stat) begin
			if (!wr_data[`CCST_ST_AUTO_SHUTDOWN_FLAG]) begin
				next_st.auto_shutdown_flag = 1'b0;
			end
			if (!wr_data[`CCST_ST_SINGLE_EDGE_COMPARE_FLAG]) begin
				next_st.single_edge_compare_flag = 1'b0;
			end
			if (!wr_data[`CCST_ST_CAPTURE_DISABLE_FLAG]) begin
				next_st.capture_disable_flag = 1'b0;
			end
			if (!wr_data[`CCST_ST_CAPTURE_OVERFLOW_FLAG]) begin
				next_st.capture_overflow_flag = 1'b0;
			end
		end
		if (wr_exec && wr_strb[0] && (wr_addr == ADDR_W'(`CCST_OFF_CTRL))) begin
			next_st.trigger_enable_setting = wr_data[`CCST_CT_TRIGGER_ENABLE_SETTING];
			next_st.capture_gating_mode    = ccst_pkg::ccst_gsm_t'(wr_data[`CCST_CT_GSM_LO +: 2]);
			next_st.shutdown_state_group_a = ccst_pkg::ccst_pss_t'(wr_data[`CCST_CT_PSSA_LO +: 2]);
			next_st.shutdown_state_group_b = ccst_pkg::ccst_pss_t'(wr_data[`CCST_CT_PSSB_LO +: 2]);
		end
		if (wr_exec && wr_strb[0] && (wr_addr == ADDR_W'(`CCST_OFF_IRQ_STAT))) begin
			next_st.irq_stat = st.irq_stat & ~wr_data[3:0];
		end
		if (wr_exec && wr_strb[0] && (wr_addr == ADDR_W'(`CCST_OFF_IRQ_MASK))) begin
			next_st.irq_mask = wr_data[3:0];
		end

		// trigger: free running unless triggered mode is selected; set wins over clear
		if (!st.trigger_enable_setting) begin
			next_st.trigger_running_flag = 1'b1;
		end else if (wr_stat && wr_data[`CCST_ST_TRIGGER_SET_REQUEST]) begin
			next_st.trigger_running_flag = 1'b1;
		end else if (wr_stat && wr_data[`CCST_ST_TRIGGER_CLEAR_REQUEST]) begin
			next_st.trigger_running_flag = 1'b0;
		end

		// hardware sets come after the software clears
		if (sd_s) begin
			next_st.auto_shutdown_flag = 1'b1;
			if (!st.auto_shutdown_flag) begin
				next_st.irq_stat[`CCST_IRQ_SHDN] = 1'b1;
			end
		end
		if (compare_match) begin
			next_st.single_edge_compare_flag    = 1'b1;
			next_st.irq_stat[`CCST_IRQ_CMP] = 1'b1;
		end
		case (st.capture_gating_mode)
			ccst_pkg::CCST_GSM_LEVEL: begin
				next_st.capture_disable_flag = !gate_s;
			end
			ccst_pkg::CCST_GSM_ONE_RISE: begin
				if (gate_rise) begin
					next_st.capture_disable_flag = 1'b0;
				end
			end
			ccst_pkg::CCST_GSM_ONE_FALL: begin
				if (gate_fall) begin
					next_st.capture_disable_flag = 1'b1;
				end
			end
			default: begin
			end
		endcase

		// capture buffer; a read in the same cycle makes room
		if (rd_pop) begin
			next_st.rptr = PTR_W'(st.rptr + 1'b1);
		end
		if (cap_rise && !st.capture_disable_flag) begin
			if ((st.cnt == CNT_W'(DEPTH)) && !rd_pop) begin
				next_st.capture_overflow_flag = 1'b1;
				next_st.irq_stat[`CCST_IRQ_OVF] = 1'b1;
			end else begin
				push = 1'b1;
				next_st.fifo[st.wptr] = time_base_value;
				next_st.wptr = PTR_W'(st.wptr + 1'b1);
				next_st.irq_stat[`CCST_IRQ_CAP] = 1'b1;
			end
		end
		next_st.cnt = CNT_W'(st.cnt + CNT_W'(push) - CNT_W'(rd_pop));

		// read channel
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (ar_hs) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = ccst_mapped(s_axi_araddr) ? ccst_pkg::CCST_RESP_OKAY : ccst_pkg::CCST_RESP_SLVERR;
			next_st.rdata  = '0;
			case (s_axi_araddr)
				ADDR_W'(`CCST_OFF_STATUS): begin
					next_st.rdata[`CCST_ST_TRIG]  = st.trigger_running_flag;
					next_st.rdata[`CCST_ST_AUTO_SHUTDOWN_FLAG] = st.auto_shutdown_flag;
					next_st.rdata[`CCST_ST_SINGLE_EDGE_COMPARE_FLAG] = st.single_edge_compare_flag;
					next_st.rdata[`CCST_ST_CAPTURE_DISABLE_FLAG] = st.capture_disable_flag;
					next_st.rdata[`CCST_ST_CAPTURE_OVERFLOW_FLAG]  = st.capture_overflow_flag;
					next_st.rdata[`CCST_ST_CAPTURE_BUFFER_NOT_EMPTY] = (st.cnt != '0);
				end
				ADDR_W'(`CCST_OFF_CTRL): begin
					next_st.rdata[`CCST_CT_TRIGGER_ENABLE_SETTING]       = st.trigger_enable_setting;
					next_st.rdata[`CCST_CT_GSM_LO +: 2]  = st.capture_gating_mode;
					next_st.rdata[`CCST_CT_PSSA_LO +: 2] = st.shutdown_state_group_a;
					next_st.rdata[`CCST_CT_PSSB_LO +: 2] = st.shutdown_state_group_b;
				end
				ADDR_W'(`CCST_OFF_CAPBUF): begin
					if (st.cnt != '0) begin
						next_st.rdata = 32'(st.fifo[st.rptr]);
					end
				end
				ADDR_W'(`CCST_OFF_IRQ_STAT): begin
					next_st.rdata[3:0] = st.irq_stat;
				end
				ADDR_W'(`CCST_OFF_IRQ_MASK): begin
					next_st.rdata[3:0] = st.irq_mask;
				end
				default: begin
				end
			endcase
		end
		next_st.arready = !next_st.rvalid;

		// outputs
		{next_st.out_a, next_st.out_a_oe_n} =
			ccst_drive(st.shutdown_state_group_a, pwm_a, st.auto_shutdown_flag);
		{next_st.out_b, next_st.out_b_oe_n} =
			ccst_drive(st.shutdown_state_group_b, pwm_b, st.auto_shutdown_flag);
		next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st          <= '0;
			st.irq_mask <= `CCST_RST_MASK;
			{st.shutdown_state_group_b, st.shutdown_state_group_a, st.capture_gating_mode,
				st.trigger_enable_setting} <= `CCST_RST_CTRL;
		end else begin
			st <= next_st;
		end
	end

	// ==================================================
	// outputs
	assign s_axi_awready        = st.awready;
	assign s_axi_wready         = st.wready;
	assign s_axi_bvalid         = st.bvalid;
	assign s_axi_bresp          = st.bresp;
	assign s_axi_arready        = st.arready;
	assign s_axi_rvalid         = st.rvalid;
	assign s_axi_rresp          = st.rresp;
	assign s_axi_rdata          = st.rdata;
	assign trigger_running_flag = st.trigger_running_flag;
	assign out_a                = st.out_a;
	assign out_a_oe_n           = st.out_a_oe_n;
	assign out_b                = st.out_b;
	assign out_b_oe_n           = st.out_b_oe_n;
	assign irq                  = st.irq;

	// ==================================================
	// assertions
	default clocking ccst_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	trig_read_a: assert property (ar_hs && (s_axi_araddr == ADDR_W'(`CCST_OFF_STATUS))
		|=> s_axi_rdata[`CCST_ST_TRIG] == $past(st.trigger_running_flag))
		else $error("status read does not show trigger state");
	trig_set_a: assert property (wr_stat && st.trigger_enable_setting && wr_data[`CCST_ST_TRIGGER_SET_REQUEST]
		|=> trigger_running_flag)
		else $error("trigger set request ignored");
	trig_clr_a: assert property (wr_stat && st.trigger_enable_setting && wr_data[`CCST_ST_TRIGGER_CLEAR_REQUEST]
		&& !wr_data[`CCST_ST_TRIGGER_SET_REQUEST] |=> !trigger_running_flag)
		else $error("trigger clear request ignored");
	stat_zero_a: assert property (ar_hs && (s_axi_araddr == ADDR_W'(`CCST_OFF_STATUS))
		|=> (s_axi_rdata[31:8] == '0) && !s_axi_rdata[`CCST_ST_TRIGGER_SET_REQUEST] && !s_axi_rdata[`CCST_ST_TRIGGER_CLEAR_REQUEST])
		else $error("status write-only or upper bits read nonzero");
	shdn_out_a: assert property (sd_s ##1 (st.shutdown_state_group_a == ccst_pkg::CCST_PSS_ACTIVE)
		|=> out_a && !out_a_oe_n)
		else $error("shutdown did not force group a active");
	cmp_flag_a: assert property (compare_match |=> st.single_edge_compare_flag [*2]
		or (st.single_edge_compare_flag ##1 $past(wr_stat)))
		else $error("compare event flag not held");
	cap_block_a: assert property (st.capture_disable_flag && cap_rise && !rd_pop
		|=> st.cnt == $past(st.cnt))
		else $error("capture taken while disabled");
	ovf_set_a: assert property (cap_rise && !st.capture_disable_flag && (st.cnt == CNT_W'(DEPTH)) && !rd_pop
		|=> st.capture_overflow_flag && (st.cnt == CNT_W'(DEPTH)))
		else $error("overflow not flagged on full buffer");
	bne_first_a: assert property (cap_rise && !st.capture_disable_flag && (st.cnt == '0)
		|=> st.cnt == CNT_W'(1))
		else $error("first capture not stored");
	gate_fall_a: assert property ((st.capture_gating_mode == ccst_pkg::CCST_GSM_ONE_FALL) && gate_fall
		|=> st.capture_disable_flag)
		else $error("gating falling edge did not disable capture");
	irq_level_a: assert property (|(st.irq_stat & st.irq_mask) |-> irq)
		else $error("interrupt low while unmasked status set");

	trig_cover_c: cover property (wr_stat && st.trigger_enable_setting && wr_data[`CCST_ST_TRIGGER_SET_REQUEST]);
	ovf_cover_c: cover property (st.capture_overflow_flag && rd_pop);
	shdn_cover_c: cover property (st.auto_shutdown_flag && out_a_oe_n);
	irq_cover_c: cover property ($rose(irq));

endmodule

// ---- bench/tb_top.sv ----
// self-checking bench of the status/trigger block with an AXI4-Lite master
`include "ccst_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================
	// signals
	localparam logic [1:0] OK = ccst_pkg::CCST_RESP_OKAY;
	localparam logic [1:0] ER = ccst_pkg::CCST_RESP_SLVERR;
	localparam logic [7:0] ST = `CCST_OFF_STATUS;
	localparam logic [7:0] CT = `CCST_OFF_CTRL;
	localparam logic [7:0] CB = `CCST_OFF_CAPBUF;
	localparam logic [7:0] IS = `CCST_OFF_IRQ_STAT;
	localparam logic [7:0] IM = `CCST_OFF_IRQ_MASK;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        cap = 1'b0;
	logic        gate = 1'b1;
	logic        shdn = 1'b0;
	logic        cmp = 1'b0;
	logic [15:0] tbv = 16'h0;
	logic        pwm_a = 1'b0;
	logic        pwm_b = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, running, out_a, out_a_oe_n, out_b, out_b_oe_n, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [33:0] exp_q[$];
	logic [15:0] vals[5];
	logic [31:0] seed = 32'd27;
	int          errors = 0;
	int          samples_checked = 0;
	always #5 aclk = ~aclk;
	ccst_status uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .capture_pin(cap),
		.gate_pin(gate), .shutdown_pin(shdn), .compare_match(cmp), .time_base_value(tbv),
		.pwm_a(pwm_a), .pwm_b(pwm_b), .trigger_running_flag(running), .out_a(out_a),
		.out_a_oe_n(out_a_oe_n), .out_b(out_b), .out_b_oe_n(out_b_oe_n), .irq(irq)
	);
	// ==================================================
	// helpers
	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input logic [33:0] seen, input logic [33:0] expd);
		samples_checked++;
		if (seen !== expd) begin
			errors++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, expd);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		check(bresp, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
	endtask
	task automatic pulse_cap(input logic [15:0] v);
		tbv <= v;
		cap <= 1'b1;
		tick(5);
		cap <= 1'b0;
		tick(5);
	endtask
	task automatic results();
		$display("checked %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==================================================
	// read data monitor
	always @(posedge aclk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check({rresp, rdata}, 34'h3_FFFF_FFFF);
			end else begin
				check({rresp, rdata}, exp_q.pop_front());
			end
		end
	end
	initial begin
		tick(20000);
		errors++;
		results();
	end
	// ==================================================
	// tests
	initial begin
		logic [31:0] tw[4] = '{32'h0000_FF20, 32'h40, 32'h20, 32'h60};
		logic [31:0] te[4] = '{32'h00, 32'h80, 32'h00, 32'h80};
		logic [1:0] c;
		logic [31:0] r;
		tick(16);
		aresetn <= 1'b1;
		tick(4);
		rd(ST, {OK, 32'h80});
		check(running, 1'b1);
		rd(CT, {OK, 32'h0});
		rd(IM, {OK, 32'h0});
		rd(IS, {OK, 32'h0});
		rd(CB, {OK, 32'h0});
		rd(8'h14, {ER, 32'h0});
		wr(8'h14, 32'hFF, ER);
		$display("reset and map test done");
		wr(CT, 32'h01, OK);
		for (int i = 0; i < 4; i++) begin
			wr(ST, tw[i], OK);
			rd(ST, {OK, te[i]});
			tick(1);
			check(running, te[i][7]);
		end
		wr(CT, 32'h00, OK);
		wr(ST, 32'h20, OK);
		rd(ST, {OK, 32'h80});
		wr(CT, 32'h01, OK);
		$display("trigger test done");
		wr(IS, 32'h0F, OK);
		cmp <= 1'b1;
		tick(1);
		cmp <= 1'b0;
		rd(ST, {OK, 32'h88});
		rd(IS, {OK, 32'h02});
		wr(ST, 32'h00, OK);
		rd(ST, {OK, 32'h80});
		cmp <= 1'b1;
		wr(ST, 32'h00, OK);
		cmp <= 1'b0;
		rd(ST, {OK, 32'h88});
		wr(ST, 32'h00, OK);
		wr(IS, 32'h0F, OK);
		$display("compare test done");
		for (int i = 0; i < 5; i++) begin
			r = xorshift();
			vals[i] = r[15:0];
			pulse_cap(vals[i]);
		end
		rd(ST, {OK, 32'h83});
		rd(IS, {OK, 32'h0C});
		check(irq, 1'b0);
		wr(IM, 32'h04, OK);
		tick(2);
		check(irq, 1'b1);
		for (int i = 0; i < 4; i++) rd(CB, {OK, 16'h0, vals[i]});
		rd(CB, {OK, 32'h0});
		rd(ST, {OK, 32'h82});
		wr(IS, 32'h04, OK);
		tick(2);
		check(irq, 1'b0);
		wr(ST, 32'h00, OK);
		rd(ST, {OK, 32'h80});
		wr(IM, 32'h00, OK);
		wr(IS, 32'h0F, OK);
		$display("capture and interrupt test done");
		gate <= 1'b0;
		tick(6);
		rd(ST, {OK, 32'h84});
		pulse_cap(16'h1234);
		rd(ST, {OK, 32'h84});
		wr(CT, 32'h03, OK);
		gate <= 1'b1;
		tick(6);
		rd(ST, {OK, 32'h80});
		wr(CT, 32'h05, OK);
		gate <= 1'b0;
		tick(6);
		rd(ST, {OK, 32'h84});
		gate <= 1'b1;
		tick(6);
		rd(ST, {OK, 32'h84});
		wr(ST, 32'h00, OK);
		rd(ST, {OK, 32'h80});
		wr(CT, 32'h01, OK);
		$display("gating test done");
		r = xorshift();
		c = r[1:0];
		pwm_a <= c[0];
		pwm_b <= c[1];
		shdn <= 1'b1;
		tick(6);
		rd(ST, {OK, 32'h90});
		rd(IS, {OK, 32'h01});
		wr(ST, 32'h00, OK);
		rd(ST, {OK, 32'h90});
		for (int k = 3; k >= 0; k--) begin
			wr(CT, 32'h01 | (k << 3) | (k << 5), OK);
			tick(2);
			check({out_a, out_a_oe_n, out_b, out_b_oe_n}, {k == 3, k < 2, k == 3, k < 2});
		end
		shdn <= 1'b0;
		tick(6);
		wr(ST, 32'h00, OK);
		tick(3);
		check({out_a, out_a_oe_n, out_b, out_b_oe_n}, {c[0], 1'b0, c[1], 1'b0});
		rd(ST, {OK, 32'h80});
		$display("shutdown test done");
		tick(4);
		results();
	end
endmodule
